// *** cpu_bus_model.sv ***
// Behavioural CPU reaching the bank with byte memory cycles.
`timescale 1ns/100ps
`default_nettype none
module cpu_bus_model (
  input  wire logic        sys_clk_i,
  input  wire logic [7:0]  rdata_i,
  output var  logic [15:0] addr_o,
  output var  logic        wr_en_o,
  output var  logic        rd_en_o,
  output var  logic [7:0]  wdata_o
);
  initial begin
    addr_o = 16'hffff;
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
    wdata_o = 8'h00;
  end
  // Idle lines show the inverse of the last value, so nothing leans on stale data.
  task automatic bus_write(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_en_o <= 1'b1;
    @(posedge sys_clk_i);
    wr_en_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask
  task automatic bus_read(input logic [15:0] a, output logic [7:0] d);
    @(posedge sys_clk_i);
    addr_o <= a;
    rd_en_o <= 1'b1;
    @(posedge sys_clk_i);
    rd_en_o <= 1'b0;
    addr_o <= ~a;
    #1;
    d = rdata_i;
  endtask
endmodule // cpu_bus_model
`default_nettype wire

// *** sfr_bank_asserts.sv ***
// Concurrent checks on the special function bank ports.
`timescale 1ns/100ps
`default_nettype none
`include "sfr_bank_regs.vh"
module sfr_bank_asserts (
  input wire logic                    sys_clk_i,
  input wire logic                    rst_i,
  input wire logic                    power_up_clear_i,
  input wire logic                    pin_reset_i,
  input wire logic [15:0]             addr_i,
  input wire logic                    wr_en_i,
  input wire logic                    rd_en_i,
  input wire logic [7:0]              wdata_i,
  input wire logic                    watchdog_event_i,
  input wire logic                    nmi_event_i,
  input wire logic                    serial_rx_event_i,
  input wire logic [7:0]              rdata_o,
  input wire logic                    watchdog_irq_en_o,
  input wire logic                    serial_rx_irq_en_o,
  input wire logic                    serial_tx_irq_en_o,
  input wire logic                    serial_rx_module_en_o,
  input wire logic                    serial_tx_module_en_o,
  input wire logic [`SFR_IRQ_NUM-1:0] irq_req_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  logic       quiet;
  logic [4:0] ens;
  logic       bank;
  assign quiet = !wr_en_i && !power_up_clear_i && !pin_reset_i;
  assign bank = addr_i[15:4] == 12'h000;
  assign ens = {watchdog_irq_en_o, serial_rx_irq_en_o, serial_tx_irq_en_o,
                serial_rx_module_en_o, serial_tx_module_en_o};
  // A flag is only owed a request while no write or clear can undo it.
  property p_set(ev, en, irq);
    (ev && en && quiet) ##1 quiet |=> irq;
  endproperty
  AST_WDT_SET: assert property (p_set(watchdog_event_i, watchdog_irq_en_o, irq_req_o[0]))
    else $error("watchdog request missing");
  AST_NMI_SET: assert property (p_set(nmi_event_i, 1'b1, irq_req_o[4]))
    else $error("nmi request missing");
  AST_RX_SET: assert property (p_set(serial_rx_event_i, serial_rx_irq_en_o, irq_req_o[5]))
    else $error("receive request missing");
  AST_TX_MASK: assert property (!serial_tx_irq_en_o [*2] |=> !irq_req_o[6])
    else $error("masked transmit request");
  AST_IE1_WRITE: assert property (wr_en_i && addr_i == 16'h0000 && !power_up_clear_i
    |=> watchdog_irq_en_o == $past(wdata_i[0])) else $error("enable byte 0 write lost");
  AST_IE2_WRITE: assert property (wr_en_i && addr_i == 16'h0001 && !power_up_clear_i
    |=> ens[3:2] == {$past(wdata_i[0]), $past(wdata_i[1])})
    else $error("enable byte 1 write lost");
  AST_ME2_WRITE: assert property (wr_en_i && addr_i == 16'h0005 && !power_up_clear_i
    |=> ens[1:0] == {$past(wdata_i[0]), $past(wdata_i[1])})
    else $error("module enable write lost");
  AST_PUC_CLEAR: assert property (power_up_clear_i |=> ens == 5'h00)
    else $error("enables survive clear");
  AST_OUTSIDE: assert property (wr_en_i && !bank && !power_up_clear_i |=> $stable(ens))
    else $error("write outside bank took effect");
  AST_ME1_READ: assert property (rd_en_i && addr_i == 16'h0004 |=> rdata_o == 8'h00)
    else $error("module enable byte 0 not empty");
  AST_RDATA_HOLD: assert property (!(rd_en_i && bank) |=> $stable(rdata_o))
    else $error("read data moved without bank read");
  cover property (wr_en_i && addr_i == 16'h0005);
  cover property (power_up_clear_i && serial_rx_event_i);
  cover property (irq_req_o[4]);
endmodule // sfr_bank_asserts
`default_nettype wire

// *** sfr_bank_regs.vh ***
// Register offsets, field positions, masks and reset values of the special function bank.
`ifndef SFR_BANK_REGS_VH
`define SFR_BANK_REGS_VH

// Byte offsets inside the bank.
`define SFR_IE_ONE_OFF      4'h0
`define SFR_IE_TWO_OFF      4'h1
`define SFR_IF_ONE_OFF      4'h2
`define SFR_IF_TWO_OFF      4'h3
`define SFR_ME_ONE_OFF      4'h4
`define SFR_ME_TWO_OFF      4'h5

// Upper address bits that select the bank (0000h..000Fh).
`define SFR_BASE_HI         12'h000

// First enable and flag byte fields.
`define SFR_WDT_BIT         0
`define SFR_OSC_BIT         1
`define SFR_PIN0_BIT        2
`define SFR_PIN1_BIT        3
`define SFR_NMI_BIT         4

// Second enable and flag byte fields.
`define SFR_RX_BIT          0
`define SFR_TX_BIT          1
`define SFR_TP_BIT          3
`define SFR_BT_BIT          7

// Implemented bits of each byte; all other positions hold no storage.
`define SFR_IE_ONE_MASK     8'h0f
`define SFR_IE_TWO_MASK     8'h8b
`define SFR_IF_ONE_MASK     8'h1f
`define SFR_IF_TWO_MASK     8'h83
`define SFR_ME_ONE_MASK     8'h00
`define SFR_ME_TWO_MASK     8'h03

// Values after the supply power-on reset.
`define SFR_IE_ONE_RST      8'h00
`define SFR_IE_TWO_RST      8'h00
`define SFR_IF_ONE_RST      8'h02
`define SFR_IF_TWO_RST      8'h00
`define SFR_ME_TWO_RST      8'h00

// Values loaded by a power-up clear pulse on bits it touches.
`define SFR_IF_ONE_PUC      8'h02
`define SFR_ZERO_BYTE       8'h00

// Number of interrupt request lines.
`define SFR_IRQ_NUM         9

`endif

// *** sfr_bus_decode.v ***
// Address decode of the special function bank on the on-chip memory bus.
`timescale 1ns/100ps
`default_nettype none
`include "sfr_bank_regs.vh"

module sfr_bus_decode (
  input  wire [15:0] addr_i,
  input  wire        wr_en_i,
  input  wire        rd_en_i,
  output wire [5:0]  wr_sel_o,
  output wire        rd_hit_o
);

  // One-hot select of the six byte slots; zero outside the bank.
  function [5:0] slot_sel;
    input [15:0] a;
    begin
      slot_sel = 6'h00;
      if (a[15:4] == `SFR_BASE_HI) begin
        case (a[3:0])
          `SFR_IE_ONE_OFF: slot_sel = 6'h01;
          `SFR_IE_TWO_OFF: slot_sel = 6'h02;
          `SFR_IF_ONE_OFF: slot_sel = 6'h04;
          `SFR_IF_TWO_OFF: slot_sel = 6'h08;
          `SFR_ME_ONE_OFF: slot_sel = 6'h10;
          `SFR_ME_TWO_OFF: slot_sel = 6'h20;
          default:         slot_sel = 6'h00;
        endcase
      end
    end
  endfunction

  assign wr_sel_o = wr_en_i ? slot_sel(addr_i) : 6'h00;
  assign rd_hit_o = rd_en_i & (addr_i[15:4] == `SFR_BASE_HI);

endmodule // sfr_bus_decode
`default_nettype wire

// *** sfr_byte_reg.v ***
// One byte of the bank with storage only on implemented bit positions.
`timescale 1ns/100ps
`default_nettype none

module sfr_byte_reg #(
  parameter [7:0] MASK = 8'hff,
  parameter [7:0] RST  = 8'h00,
  parameter [7:0] INIT = 8'h00
) (
  input  wire       sys_clk_i,
  input  wire       rst_i,
  input  wire       wr_i,
  input  wire [7:0] wdata_i,
  input  wire [7:0] set_i,
  input  wire [7:0] init_i,
  output wire [7:0] q_o
);

  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_bit
      if (MASK[i]) begin : g_store
        reg bit_q;
        // A hardware set wins over a same-cycle write or clear, so no event is lost.
        always @(posedge sys_clk_i or posedge rst_i) begin
          if (rst_i) begin
            bit_q <= RST[i];
          end else if (set_i[i]) begin
            bit_q <= 1'b1;
          end else if (init_i[i]) begin
            bit_q <= INIT[i];
          end else if (wr_i) begin
            bit_q <= wdata_i[i];
          end
        end
        assign q_o[i] = bit_q;
      end else begin : g_empty
        assign q_o[i] = 1'b0;
      end
    end
  endgenerate

endmodule // sfr_byte_reg
`default_nettype wire

// *** sfr_interrupt_module_enable_bank.v ***
// Special function bank: interrupt enables, interrupt flags and module enables.
`timescale 1ns/100ps
`default_nettype none
`include "sfr_bank_regs.vh"

module sfr_interrupt_module_enable_bank (
  input  wire                     sys_clk_i,
  input  wire                     rst_i,
  input  wire                     power_up_clear_i,
  input  wire                     pin_reset_i,
  input  wire [15:0]              addr_i,
  input  wire                     wr_en_i,
  input  wire                     rd_en_i,
  input  wire [7:0]               wdata_i,
  input  wire                     watchdog_event_i,
  input  wire                     osc_fault_event_i,
  input  wire                     pin_zero_event_i,
  input  wire                     pin_one_event_i,
  input  wire                     nmi_event_i,
  input  wire                     serial_rx_event_i,
  input  wire                     serial_tx_event_i,
  input  wire                     base_timer_event_i,
  input  wire                     timer_port_flag_i,
  output reg  [7:0]               rdata_o,
  output wire                     watchdog_irq_en_o,
  output wire                     osc_fault_irq_en_o,
  output wire                     pin_zero_irq_en_o,
  output wire                     pin_one_irq_en_o,
  output wire                     serial_rx_irq_en_o,
  output wire                     serial_tx_irq_en_o,
  output wire                     timer_port_irq_en_o,
  output wire                     base_timer_irq_en_o,
  output wire                     serial_rx_module_en_o,
  output wire                     serial_tx_module_en_o,
  output reg  [`SFR_IRQ_NUM-1:0]  irq_req_o
);

  wire [5:0] wr_sel;
  wire       rd_hit;
  wire [7:0] ie_one_q;
  wire [7:0] ie_two_q;
  wire [7:0] if_one_q;
  wire [7:0] if_two_q;
  wire [7:0] me_two_q;
  wire [7:0] if_one_set;
  wire [7:0] if_one_init;
  wire [7:0] if_two_set;
  wire [7:0] if_two_init;
  wire [7:0] puc_all;
  reg  [7:0] rd_mux;
  reg  [`SFR_IRQ_NUM-1:0] irq_d;

  assign puc_all = {8{power_up_clear_i}};

  // Byte transfers only; the CPU drives one strobe per access cycle.
  sfr_bus_decode u_decode (
    .addr_i   (addr_i),
    .wr_en_i  (wr_en_i),
    .rd_en_i  (rd_en_i),
    .wr_sel_o (wr_sel),
    .rd_hit_o (rd_hit)
  );

  // First enable byte: watchdog, oscillator fault and the two dedicated pins.
  sfr_byte_reg #(
    .MASK (`SFR_IE_ONE_MASK),
    .RST  (`SFR_IE_ONE_RST),
    .INIT (`SFR_ZERO_BYTE)
  ) u_ie_one (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .wr_i      (wr_sel[0]),
    .wdata_i   (wdata_i),
    .set_i     (8'h00),
    .init_i    (puc_all),
    .q_o       (ie_one_q)
  );

  // Second enable byte: serial receive, transmit, timer/port and basic timer.
  sfr_byte_reg #(
    .MASK (`SFR_IE_TWO_MASK),
    .RST  (`SFR_IE_TWO_RST),
    .INIT (`SFR_ZERO_BYTE)
  ) u_ie_two (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .wr_i      (wr_sel[1]),
    .wdata_i   (wdata_i),
    .set_i     (8'h00),
    .init_i    (puc_all),
    .q_o       (ie_two_q)
  );

  // Watchdog flag survives a clear caused by the watchdog itself; only the
  // supply reset, a pin reset or a write of the first flag byte removes it, so software can tell the cause.
  assign if_one_set = {3'h0,
                       nmi_event_i,
                       pin_one_event_i,
                       pin_zero_event_i,
                       osc_fault_event_i,
                       watchdog_event_i};
  assign if_one_init = {3'h0,
                        {4{power_up_clear_i}},
                        pin_reset_i};

  sfr_byte_reg #(
    .MASK (`SFR_IF_ONE_MASK),
    .RST  (`SFR_IF_ONE_RST),
    .INIT (`SFR_IF_ONE_PUC)
  ) u_if_one (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .wr_i      (wr_sel[2]),
    .wdata_i   (wdata_i),
    .set_i     (if_one_set),
    .init_i    (if_one_init),
    .q_o       (if_one_q)
  );

  // Basic timer flag keeps its value across a power-up clear.
  assign if_two_set = {base_timer_event_i, 5'h00,
                       serial_tx_event_i, serial_rx_event_i};
  assign if_two_init = {1'b0, 5'h00, power_up_clear_i, power_up_clear_i};

  sfr_byte_reg #(
    .MASK (`SFR_IF_TWO_MASK),
    .RST  (`SFR_IF_TWO_RST),
    .INIT (`SFR_ZERO_BYTE)
  ) u_if_two (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .wr_i      (wr_sel[3]),
    .wdata_i   (wdata_i),
    .set_i     (if_two_set),
    .init_i    (if_two_init),
    .q_o       (if_two_q)
  );

  // Second module enable byte; the first module enable byte is empty.
  sfr_byte_reg #(
    .MASK (`SFR_ME_TWO_MASK),
    .RST  (`SFR_ME_TWO_RST),
    .INIT (`SFR_ZERO_BYTE)
  ) u_me_two (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .wr_i      (wr_sel[5]),
    .wdata_i   (wdata_i),
    .set_i     (8'h00),
    .init_i    (puc_all),
    .q_o       (me_two_q)
  );

  assign watchdog_irq_en_o     = ie_one_q[`SFR_WDT_BIT];
  assign osc_fault_irq_en_o    = ie_one_q[`SFR_OSC_BIT];
  assign pin_zero_irq_en_o     = ie_one_q[`SFR_PIN0_BIT];
  assign pin_one_irq_en_o      = ie_one_q[`SFR_PIN1_BIT];
  assign serial_rx_irq_en_o    = ie_two_q[`SFR_RX_BIT];
  assign serial_tx_irq_en_o    = ie_two_q[`SFR_TX_BIT];
  assign timer_port_irq_en_o   = ie_two_q[`SFR_TP_BIT];
  assign base_timer_irq_en_o   = ie_two_q[`SFR_BT_BIT];
  assign serial_rx_module_en_o = me_two_q[`SFR_RX_BIT];
  assign serial_tx_module_en_o = me_two_q[`SFR_TX_BIT];

  // Read mux; unmapped offsets and the empty byte read as zero.
  always @* begin
    case (addr_i[3:0])
      `SFR_IE_ONE_OFF: rd_mux = ie_one_q;
      `SFR_IE_TWO_OFF: rd_mux = ie_two_q;
      `SFR_IF_ONE_OFF: rd_mux = if_one_q;
      `SFR_IF_TWO_OFF: rd_mux = if_two_q;
      `SFR_ME_ONE_OFF: rd_mux = `SFR_ZERO_BYTE;
      `SFR_ME_TWO_OFF: rd_mux = me_two_q;
      default:         rd_mux = `SFR_ZERO_BYTE;
    endcase
  end

  // Read data is registered and holds until the next read of the bank.
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_hit) begin
      rdata_o <= rd_mux;
    end
  end

  // The NMI line has no enable in this bank and the timer/port flag lives
  // in its own module, so the NMI request passes straight through and the timer/port request is timer_port_flag_i gated by its enable.
  always @* begin
    irq_d    = {`SFR_IRQ_NUM{1'b0}};
    irq_d[0] = if_one_q[`SFR_WDT_BIT] & ie_one_q[`SFR_WDT_BIT];
    irq_d[1] = if_one_q[`SFR_OSC_BIT] & ie_one_q[`SFR_OSC_BIT];
    irq_d[2] = if_one_q[`SFR_PIN0_BIT] & ie_one_q[`SFR_PIN0_BIT];
    irq_d[3] = if_one_q[`SFR_PIN1_BIT] & ie_one_q[`SFR_PIN1_BIT];
    irq_d[4] = if_one_q[`SFR_NMI_BIT];
    irq_d[5] = if_two_q[`SFR_RX_BIT] & ie_two_q[`SFR_RX_BIT];
    irq_d[6] = if_two_q[`SFR_TX_BIT] & ie_two_q[`SFR_TX_BIT];
    irq_d[7] = timer_port_flag_i & ie_two_q[`SFR_TP_BIT];
    irq_d[8] = if_two_q[`SFR_BT_BIT] & ie_two_q[`SFR_BT_BIT];
  end

  // Requests are registered, so they follow flag and enable by one cycle.
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_req_o <= {`SFR_IRQ_NUM{1'b0}};
    end else begin
      irq_req_o <= irq_d;
    end
  end

endmodule // sfr_interrupt_module_enable_bank
`default_nettype wire

// *** tb_sfr_interrupt_module_enable_bank.sv ***
// Self-checking bench for the special function bank.
`timescale 1ns/100ps
`default_nettype none
`include "sfr_bank_regs.vh"
module tb_sfr_interrupt_module_enable_bank;
  logic        sys_clk;
  logic        rst;
  logic        power_up_clear;
  logic        prs;
  logic        tp;
  logic [7:0]  ev;
  logic [7:0]  mdl [0:15];
  logic [7:0]  msk [0:15];
  logic [15:0] a;
  integer      errors;
  integer      comparisons;
  wire  [15:0] addr;
  wire         wr_en;
  wire         rd_en;
  wire  [7:0]  wdata;
  wire  [7:0]  rdata;
  wire  [7:0]  ien;
  wire  [1:0]  men;
  wire  [8:0]  irq;
  cpu_bus_model cpu_bus_model_inst (.sys_clk_i(sys_clk), .rdata_i(rdata), .addr_o(addr),
    .wr_en_o(wr_en), .rd_en_o(rd_en), .wdata_o(wdata));
  sfr_interrupt_module_enable_bank sfr_interrupt_module_enable_bank_inst (
    .sys_clk_i(sys_clk), .rst_i(rst), .power_up_clear_i(power_up_clear), .pin_reset_i(prs),
    .addr_i(addr), .wr_en_i(wr_en), .rd_en_i(rd_en), .wdata_i(wdata),
    .watchdog_event_i(ev[0]), .osc_fault_event_i(ev[1]), .pin_zero_event_i(ev[2]),
    .pin_one_event_i(ev[3]), .nmi_event_i(ev[4]), .serial_rx_event_i(ev[5]),
    .serial_tx_event_i(ev[6]), .base_timer_event_i(ev[7]), .timer_port_flag_i(tp),
    .rdata_o(rdata), .watchdog_irq_en_o(ien[0]), .osc_fault_irq_en_o(ien[1]),
    .pin_zero_irq_en_o(ien[2]), .pin_one_irq_en_o(ien[3]), .serial_rx_irq_en_o(ien[4]),
    .serial_tx_irq_en_o(ien[5]), .timer_port_irq_en_o(ien[6]), .base_timer_irq_en_o(ien[7]),
    .serial_rx_module_en_o(men[0]), .serial_tx_module_en_o(men[1]), .irq_req_o(irq));
  task automatic check(input logic [15:0] s, input logic [15:0] e);
    comparisons = comparisons + 1;
    if (s !== e) begin
      errors = errors + 1;
      $display("mismatch at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic rd_chk(input logic [3:0] r);
    logic [7:0] v;
    logic [8:0] x;
    cpu_bus_model_inst.bus_read({12'h000, r}, v);
    x = {mdl[3][7] & mdl[1][7], tp & mdl[1][3], mdl[3][1:0] & mdl[1][1:0], mdl[2][4],
         mdl[2][3:0] & mdl[0][3:0]};
    check(v, mdl[r]);
    check(ien, {mdl[1][7], mdl[1][3], mdl[1][1:0], mdl[0][3:0]});
    check(men, mdl[5][1:0]);
    check(irq, x);
  endtask
  task automatic wr(input logic [15:0] ad, input logic [7:0] v);
    cpu_bus_model_inst.bus_write(ad, v);
    if (ad[15:4] == 12'h000)
      mdl[ad[3:0]] = v & msk[ad[3:0]];
  endtask
  task automatic pulse(input logic [7:0] e, input logic p, input logic r);
    @(posedge sys_clk);
    ev <= e;
    power_up_clear <= p;
    prs <= r;
    @(posedge sys_clk);
    ev <= 8'h00;
    power_up_clear <= 1'b0;
    prs <= 1'b0;
    if (p) begin
      mdl[0] = 8'h00;
      mdl[1] = 8'h00;
      mdl[5] = 8'h00;
      mdl[2] = (mdl[2] & 8'h01) | 8'h02;
      mdl[3] = mdl[3] & 8'h80;
    end
    if (r)
      mdl[2][0] = 1'b0;
    mdl[2] = mdl[2] | {3'h0, e[4:0]};
    mdl[3] = mdl[3] | {e[7], 5'h00, e[6:5]};
  endtask
  task automatic stop_test;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors = errors + 1;
    stop_test;
  end
  initial begin
    rst = 1'b1;
    power_up_clear = 1'b0;
    prs = 1'b0;
    tp = 1'b0;
    ev = 8'h00;
    errors = 0;
    comparisons = 0;
    msk = '{0: `SFR_IE_ONE_MASK, 1: `SFR_IE_TWO_MASK, 2: `SFR_IF_ONE_MASK,
            3: `SFR_IF_TWO_MASK, 5: `SFR_ME_TWO_MASK, default: 8'h00};
    mdl = '{2: 8'h02, default: 8'h00};
    void'($urandom(32'h985e));
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    for (int i = 0; i < 16; i++) rd_chk(i[3:0]);
    $display("test reset_values done");
    // Half of the random addresses fall just above the bank.
    repeat (60) begin
      @(posedge sys_clk);
      tp <= 1'($urandom);
      a = 16'($urandom % 32);
      wr(a, 8'($urandom));
      rd_chk(a[3:0]);
    end
    $display("test random_access done");
    wr(16'h0000, 8'hff);
    wr(16'h0001, 8'hff);
    wr(16'h0002, 8'h00);
    wr(16'h0003, 8'h00);
    for (int i = 0; i < 8; i++) begin
      pulse(8'h01 << i, 1'b0, 1'b0);
      rd_chk(4'h2);
      rd_chk(4'h3);
    end
    $display("test events done");
    wr(16'h0005, 8'h03);
    wr(16'h0002, 8'h1f);
    pulse(8'h20, 1'b1, 1'b0);
    for (int i = 0; i < 6; i++) rd_chk(i[3:0]);
    pulse(8'h01, 1'b1, 1'b1);
    rd_chk(4'h2);
    pulse(8'h00, 1'b1, 1'b1);
    rd_chk(4'h2);
    $display("test clears done");
    stop_test;
  end
endmodule // tb_sfr_interrupt_module_enable_bank
bind sfr_interrupt_module_enable_bank sfr_bank_asserts sfr_bank_asserts_inst (.sys_clk_i,
  .rst_i, .power_up_clear_i, .pin_reset_i, .addr_i, .wr_en_i, .rd_en_i, .wdata_i,
  .watchdog_event_i, .nmi_event_i, .serial_rx_event_i, .rdata_o, .watchdog_irq_en_o,
  .serial_rx_irq_en_o, .serial_tx_irq_en_o, .serial_rx_module_en_o, .serial_tx_module_en_o,
  .irq_req_o);
`default_nettype wire
